// ### hdl/timer_unit.v
// timer unit: base counter, compare/capture channels, split mode and waveform extension
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/100ps
`include "timer_unit_defs.vh"

module timer_unit #(
  parameter FOUR_CH = 1
) (
  // clock and reset
  input  wire        ref_clk,
  input  wire        reset_n,
  // register port
  input  wire [3:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  // event system
  input  wire [7:0]  ev_in,
  output reg         ovf_event,
  output reg         err_event,
  output reg  [3:0]  comp_event,
  output reg         high_unf_event,
  // port pins
  input  wire [7:0]  port_value,
  output reg  [7:0]  pin_out,
  output reg  [7:0]  wave_out
);

  localparam NUM_CH = FOUR_CH ? 4 : 2;

  // ------------------------------------------------------------------------
  // configuration
  // ------------------------------------------------------------------------
  reg  [3:0]  clk_sel_reg;
  reg  [15:0] ctrlb_reg;
  reg  [15:0] ctrlc_reg;
  reg  [7:0]  fault_mask_reg;
  reg         fault_reg;

  wire [1:0]  wmode     = ctrlb_reg[`WMODE_HI:`WMODE_LO];
  wire [2:0]  evact     = ctrlb_reg[`EVACT_HI:`EVACT_LO];
  wire [2:0]  evsel     = ctrlb_reg[`EVSEL_HI:`EVSEL_LO];
  wire [3:0]  comp_en   = ctrlb_reg[`COMP_EN_HI:`COMP_EN_LO];
  wire        split     = (FOUR_CH != 0) && ctrlb_reg[`SPLIT_BIT];
  wire [1:0]  hires     = ctrlc_reg[`HIRES_HI:`HIRES_LO];
  wire        pat_en    = (FOUR_CH != 0) && ctrlc_reg[`PAT_EN_BIT];
  wire [3:0]  dt_en     = (FOUR_CH != 0) ? ctrlc_reg[`DT_EN_HI:`DT_EN_LO] : 4'h0;
  wire        cap_mode  = (evact == `EA_CAPTURE) || (evact == `EA_FREQCAP) || (evact == `EA_PWCAP);

  // ------------------------------------------------------------------------
  // prescaler and count clock
  // ------------------------------------------------------------------------
  function presc_hit;
    input [3:0] sel;
    input [9:0] p;
    begin
      case (sel)
        4'h1:    presc_hit = 1'b1;
        4'h2:    presc_hit = (p[0] == 1'b0);
        4'h3:    presc_hit = (p[1:0] == 2'h0);
        4'h4:    presc_hit = (p[2:0] == 3'h0);
        4'h5:    presc_hit = (p[5:0] == 6'h00);
        4'h6:    presc_hit = (p[7:0] == 8'h00);
        4'h7:    presc_hit = (p == 10'h000);
        default: presc_hit = 1'b0;
      endcase
    end
  endfunction

  reg  [9:0]  presc_reg;
  // select 8..15 counts event channel 0..7, which also chains a lower unit's overflow
  wire        base_tick = clk_sel_reg[3] ? ev_in[clk_sel_reg[2:0]] : presc_hit(clk_sel_reg, presc_reg);

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      presc_reg <= 10'h000;
    end else if (clk_sel_reg == 4'h0) begin
      presc_reg <= 10'h000;
    end else begin
      presc_reg <= presc_reg + 10'h001;
    end
  end

  // ------------------------------------------------------------------------
  // event conditioning: noise filter and optional one-cycle delay
  // ------------------------------------------------------------------------
  reg  [7:0]  ev_filt_reg;
  reg  [7:0]  ev_del_reg;
  reg  [7:0]  ev_prev_reg;
  wire [7:0]  ev_use = ctrlb_reg[`EVDELAY_BIT] ? ev_del_reg : ev_filt_reg;

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : filt
      reg [`NC_SAMPLES-2:0] hist_reg;
      always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          hist_reg       <= {(`NC_SAMPLES-1){1'b0}};
          ev_filt_reg[g] <= 1'b0;
        end else begin
          hist_reg <= {hist_reg[`NC_SAMPLES-3:0], ev_in[g]};
          // a change only passes once it has been stable for every sample
          if (!ctrlb_reg[`NC_BIT]) begin
            ev_filt_reg[g] <= ev_in[g];
          end else if (&{hist_reg, ev_in[g]} || ~|{hist_reg, ev_in[g]}) begin
            ev_filt_reg[g] <= ev_in[g];
          end
        end
      end
    end
  endgenerate

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ev_del_reg  <= 8'h00;
      ev_prev_reg <= 8'h00;
    end else begin
      ev_del_reg  <= ev_filt_reg;
      ev_prev_reg <= ev_use;
    end
  end

  wire [3:0]  cap_rise;
  wire [3:0]  cap_fall;
  generate
    for (g = 0; g < 4; g = g + 1) begin : capev
      localparam [2:0] OFS = g;
      wire [2:0] idx = evsel + OFS;
      assign cap_rise[g] = ev_use[idx] & ~ev_prev_reg[idx];
      assign cap_fall[g] = ~ev_use[idx] & ev_prev_reg[idx];
    end
  endgenerate

  // ------------------------------------------------------------------------
  // base counter state
  // ------------------------------------------------------------------------
  reg  [15:0] count_reg;
  reg  [15:0] period_reg;
  reg  [15:0] period_buf_reg;
  reg         period_bv_reg;
  reg  [15:0] comp_reg [0:3];
  reg  [15:0] comp_buf_reg [0:3];
  reg  [3:0]  comp_bv_reg;
  reg  [3:0]  cap_full_reg;
  reg         dual_down_reg;
  reg  [2:0]  phase_reg;
  reg  [15:0] dt_buf_reg;
  reg  [15:0] dt_reg;
  reg  [15:0] pat_buf_reg;
  reg  [15:0] pat_reg;
  wire        dt_busy;

  wire [2:0]  phase_max = (hires == 2'h1) ? 3'h3 : (hires == 2'h2) ? 3'h7 : 3'h0;
  wire        halt      = ctrlc_reg[`DT_HALT_BIT] & dt_busy;
  wire        cnt_tick  = base_tick & ~halt & (phase_reg == phase_max);
  wire        count_down = (wmode == `WM_DUAL) ? dual_down_reg :
                           (evact == `EA_UPDOWN) ? ev_use[evsel] : ctrlb_reg[`DIR_BIT];
  wire        at_top    = (wmode == `WM_FREQ) ? (count_reg >= comp_reg[0]) : (count_reg == period_reg);
  wire        restart   = ((evact == `EA_RESTART) || (evact == `EA_FREQCAP) || (evact == `EA_PWCAP))
                          & cap_rise[0];
  wire        wrap      = cnt_tick & (split ? (count_reg[7:0] == 8'h00) :
                          count_down ? (count_reg == 16'h0000) : (at_top & (wmode != `WM_DUAL)));
  wire        high_wrap = cnt_tick & split & (count_reg[15:8] == 8'h00);
  wire        dual_top  = cnt_tick & ~split & (wmode == `WM_DUAL) & ~dual_down_reg & (count_reg == period_reg);
  wire [18:0] count_x   = (hires == 2'h1) ? {1'b0, count_reg, phase_reg[1:0]} :
                          (hires == 2'h2) ? {count_reg, phase_reg} : {3'h0, count_reg};

  wire [3:0]  capture;
  generate
    for (g = 0; g < 4; g = g + 1) begin : capsel
      assign capture[g] = (g < NUM_CH) && comp_en[g] && !split &&
                          (((evact == `EA_CAPTURE) || (evact == `EA_FREQCAP)) ? cap_rise[g] :
                           (evact == `EA_PWCAP) ? cap_fall[g] : 1'b0);
    end
  endgenerate

  wire        wr_comp = reg_wr && (reg_addr >= `ADDR_COMP0);
  wire [1:0]  wr_idx  = reg_addr[1:0];
  integer     i, j, k;

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg      <= 16'h0000;
      period_reg     <= `PERIOD_RST;
      period_buf_reg <= `PERIOD_RST;
      period_bv_reg  <= 1'b0;
      comp_bv_reg    <= 4'h0;
      cap_full_reg   <= 4'h0;
      dual_down_reg  <= 1'b0;
      phase_reg      <= 3'h0;
      dt_buf_reg     <= 16'h0000;
      dt_reg         <= 16'h0000;
      pat_buf_reg    <= 16'h0000;
      pat_reg        <= 16'h0000;
      for (i = 0; i < 4; i = i + 1) begin
        comp_reg[i]     <= 16'h0000;
        comp_buf_reg[i] <= 16'h0000;
      end
    end else begin
      if (base_tick & ~halt) begin
        phase_reg <= (phase_reg == phase_max) ? 3'h0 : phase_reg + 3'h1;
      end
      // counter
      if (reg_wr && reg_addr == `ADDR_COUNT) begin
        count_reg <= reg_wdata;
      end else if (restart && !split) begin
        count_reg <= 16'h0000;
      end else if (split && cnt_tick) begin
        count_reg[7:0]  <= wrap ? period_reg[7:0] : count_reg[7:0] - 8'h01;
        count_reg[15:8] <= high_wrap ? period_reg[15:8] : count_reg[15:8] - 8'h01;
      end else if (cnt_tick) begin
        if (wmode == `WM_DUAL) begin
          if (dual_top) begin
            dual_down_reg <= 1'b1;
            count_reg     <= count_reg - 16'h0001;
          end else if (wrap) begin
            dual_down_reg <= 1'b0;
            count_reg     <= count_reg + 16'h0001;
          end else begin
            count_reg <= dual_down_reg ? count_reg - 16'h0001 : count_reg + 16'h0001;
          end
        end else if (count_down) begin
          count_reg <= wrap ? period_reg : count_reg - 16'h0001;
        end else begin
          count_reg <= wrap ? 16'h0000 : count_reg + 16'h0001;
        end
      end
      if (wmode != `WM_DUAL) begin
        dual_down_reg <= 1'b0;
      end
      // staged values move over at the update point so a period never tears
      if (reg_wr && reg_addr == `ADDR_PERIOD) begin
        period_buf_reg <= reg_wdata;
        period_bv_reg  <= 1'b1;
      end else if (wrap && period_bv_reg) begin
        period_reg    <= period_buf_reg;
        period_bv_reg <= 1'b0;
      end
      if (reg_wr && reg_addr == `ADDR_DEADTIME) begin
        dt_buf_reg <= reg_wdata;
      end else if (wrap) begin
        dt_reg <= dt_buf_reg;
      end
      if (reg_wr && reg_addr == `ADDR_PATTERN) begin
        pat_buf_reg <= reg_wdata;
      end else if (wrap) begin
        pat_reg <= pat_buf_reg;
      end
      for (i = 0; i < 4; i = i + 1) begin
        if (i < NUM_CH) begin
          if (capture[i]) begin
            comp_reg[i] <= count_reg;
          end else if (wr_comp && wr_idx == i[1:0] && !cap_mode) begin
            comp_buf_reg[i] <= reg_wdata;
            comp_bv_reg[i]  <= 1'b1;
          end else if (wrap && comp_bv_reg[i] && !cap_mode) begin
            comp_reg[i]    <= comp_buf_reg[i];
            comp_bv_reg[i] <= 1'b0;
          end
          // a capture landing on the read that frees the slot still holds it
          cap_full_reg[i] <= capture[i] | (cap_full_reg[i] & ~(reg_rd && reg_addr == (`ADDR_COMP0 + i[3:0])));
        end
      end
    end
  end

  // ------------------------------------------------------------------------
  // waveform generation and event outputs
  // ------------------------------------------------------------------------
  reg  [7:0]  wave_next;
  reg  [3:0]  match;
  always @* begin
    wave_next = 8'h00;
    match     = 4'h0;
    for (j = 0; j < 4; j = j + 1) begin
      if (j < NUM_CH && comp_en[j] && !cap_mode) begin
        if (split) begin
          wave_next[j]     = count_reg[7:0] < comp_reg[j][7:0];
          wave_next[j + 4] = count_reg[15:8] < comp_reg[j][15:8];
          match[j]         = cnt_tick && (count_reg[7:0] == comp_reg[j][7:0]);
        end else begin
          case (wmode)
            `WM_FREQ:   wave_next[j] = wave_out[j] ^ wrap;
            `WM_SINGLE: wave_next[j] = count_x < {3'h0, comp_reg[j]};
            `WM_DUAL:   wave_next[j] = count_x < {3'h0, comp_reg[j]};
            default:    wave_next[j] = 1'b0;
          endcase
          match[j] = cnt_tick && (count_reg == comp_reg[j]);
        end
      end
    end
  end

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wave_out       <= 8'h00;
      ovf_event      <= 1'b0;
      err_event      <= 1'b0;
      comp_event     <= 4'h0;
      high_unf_event <= 1'b0;
    end else begin
      wave_out       <= wave_next;
      ovf_event      <= wrap;
      high_unf_event <= high_wrap;
      err_event      <= |(capture & cap_full_reg);
      comp_event     <= match | capture;
    end
  end

  // ------------------------------------------------------------------------
  // dead time inserters
  // ------------------------------------------------------------------------
  wire [3:0]  low_side;
  wire [3:0]  high_side;
  wire [3:0]  dt_active;
  generate
    for (g = 0; g < 4; g = g + 1) begin : dtins
      if (FOUR_CH != 0) begin : on
        reg       w_prev_reg;
        reg       low_reg;
        reg       high_reg;
        reg [7:0] dcnt_reg;
        always @(posedge ref_clk or negedge reset_n) begin
          if (!reset_n) begin
            w_prev_reg <= 1'b0;
            low_reg    <= 1'b0;
            high_reg   <= 1'b0;
            dcnt_reg   <= 8'h00;
          end else begin
            w_prev_reg <= wave_out[g];
            // both sides stay off until the gap for this edge has run out
            if (wave_out[g] != w_prev_reg) begin
              low_reg  <= 1'b0;
              high_reg <= 1'b0;
              dcnt_reg <= wave_out[g] ? dt_reg[7:0] : dt_reg[15:8];
            end else if (dcnt_reg != 8'h00) begin
              dcnt_reg <= dcnt_reg - 8'h01;
            end else begin
              low_reg  <= wave_out[g];
              high_reg <= ~wave_out[g];
            end
          end
        end
        assign low_side[g]  = low_reg;
        assign high_side[g] = high_reg;
        assign dt_active[g] = dt_en[g] & ((dcnt_reg != 8'h00) | (wave_out[g] != w_prev_reg));
      end else begin : off
        assign low_side[g]  = 1'b0;
        assign high_side[g] = 1'b0;
        assign dt_active[g] = 1'b0;
      end
    end
  endgenerate
  assign dt_busy = |dt_active & ~pat_en;

  // ------------------------------------------------------------------------
  // pin override, pattern and fault
  // ------------------------------------------------------------------------
  wire        fault_hit = |(ev_in & fault_mask_reg);
  reg  [7:0]  pin_next;
  always @* begin
    pin_next = port_value;
    for (k = 0; k < 8; k = k + 1) begin
      if (pat_reg[k] && (pat_en || dt_en[k / 2])) begin
        if (fault_reg || fault_hit) begin
          pin_next[k] = 1'b0;
        end else if (pat_en) begin
          pin_next[k] = ctrlc_reg[`PAT_CHA_BIT] ? wave_out[0] : pat_reg[k + 8];
        end else begin
          pin_next[k] = (k % 2 == 1) ? high_side[k / 2] : low_side[k / 2];
        end
      end
    end
  end

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_out <= 8'h00;
    end else begin
      pin_out <= pin_next;
    end
  end

  // ------------------------------------------------------------------------
  // register port
  // ------------------------------------------------------------------------
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      clk_sel_reg    <= 4'h0;
      ctrlb_reg      <= `CTRL_RST;
      ctrlc_reg      <= `CTRL_RST;
      fault_mask_reg <= 8'h00;
      fault_reg      <= 1'b0;
      reg_rdata      <= 16'h0000;
    end else begin
      if (reg_wr && reg_addr == `ADDR_CLKSEL) begin
        clk_sel_reg <= reg_wdata[3:0];
      end
      if (reg_wr && reg_addr == `ADDR_CTRLB) begin
        ctrlb_reg <= reg_wdata;
      end
      if (reg_wr && reg_addr == `ADDR_CTRLC) begin
        ctrlc_reg <= reg_wdata;
      end
      if (reg_wr && reg_addr == `ADDR_FAULT) begin
        fault_mask_reg <= reg_wdata[7:0];
      end
      // a fault event in the clearing cycle keeps the flag set
      fault_reg <= fault_hit | (fault_reg & ~(reg_wr && reg_addr == `ADDR_STATUS && reg_wdata[0]));
      reg_rdata <= 16'h0000;
      if (reg_rd) begin
        if (reg_addr == `ADDR_CLKSEL) begin
          reg_rdata <= {12'h000, clk_sel_reg};
        end else if (reg_addr == `ADDR_CTRLB) begin
          reg_rdata <= ctrlb_reg;
        end else if (reg_addr == `ADDR_CTRLC) begin
          reg_rdata <= ctrlc_reg;
        end else if (reg_addr == `ADDR_STATUS) begin
          reg_rdata <= {4'h0, cap_full_reg, comp_bv_reg, 1'b0, period_bv_reg, count_down, fault_reg};
        end else if (reg_addr == `ADDR_COUNT) begin
          reg_rdata <= count_reg;
        end else if (reg_addr == `ADDR_PERIOD) begin
          reg_rdata <= period_reg;
        end else if (reg_addr == `ADDR_DEADTIME) begin
          reg_rdata <= dt_reg;
        end else if (reg_addr == `ADDR_PATTERN) begin
          reg_rdata <= pat_reg;
        end else if (reg_addr == `ADDR_FAULT) begin
          reg_rdata <= {8'h00, fault_mask_reg};
        end else if (reg_addr >= `ADDR_COMP0 && reg_addr[1:0] < NUM_CH) begin
          reg_rdata <= comp_reg[reg_addr[1:0]];
        end
      end
    end
  end

endmodule

// ### hdl/timer_unit_defs.vh
// constants for the timer unit with split mode and advanced waveform extension
// ------------------------------------------------------------------------
// Notes on behaviour
// - first variant has four compare channels, second variant only two
// - only the first variant may split into two 8-bit counters
// - capture and compare never act together; capture mode disables compare
// - two units chain into one 32-bit counter with optional 32-bit capture
// - count clock is prescaled peripheral clock or an event channel
// - events steer direction, trigger capture and restart the counter
// - base counter counts clocks or events, with direction and period
// - period and channel values are staged and applied at update
// - waveform modes: frequency, single-slope and dual-slope pulse width
// - capture offers noise cancelling, frequency, pulse width and 32-bit capture
// - overflow, error and per-channel match or capture event pulses
// - split counters always count down and flag their own underflow
// - in split mode only the low byte raises compare match events
// - split bytes share a clock, own period and compare: eight outputs
// - with the extension on, each waveform becomes a complementary pair
// - four dead time inserters: low side and inverted high side outputs
// - counting may halt while a dead time is being inserted
// - extension outputs replace port values only on overridden pins
// - staged pattern drives the port, or channel A drives every overridden pin
// - pattern generator bypasses the dead time inserters
// - selected events force a fault that disables extension outputs
// - high resolution adds 2 or 3 fraction bits to the compare
// ------------------------------------------------------------------------
`ifndef TIMER_UNIT_DEFS_VH
`define TIMER_UNIT_DEFS_VH

// register addresses
`define ADDR_CLKSEL   4'h0
`define ADDR_CTRLB    4'h1
`define ADDR_CTRLC    4'h2
`define ADDR_STATUS   4'h3
`define ADDR_COUNT    4'h4
`define ADDR_PERIOD   4'h5
`define ADDR_DEADTIME 4'h6
`define ADDR_PATTERN  4'h7
`define ADDR_FAULT    4'h8
`define ADDR_COMP0    4'hc

// control b fields
`define WMODE_LO      0
`define WMODE_HI      1
`define DIR_BIT       2
`define SPLIT_BIT     3
`define COMP_EN_LO    4
`define COMP_EN_HI    7
`define NC_BIT        8
`define EVACT_LO      9
`define EVACT_HI      11
`define EVSEL_LO      12
`define EVSEL_HI      14
`define EVDELAY_BIT   15

// control c fields
`define HIRES_LO      0
`define HIRES_HI      1
`define DT_HALT_BIT   2
`define PAT_EN_BIT    3
`define PAT_CHA_BIT   4
`define DT_EN_LO      8
`define DT_EN_HI      11

// modes and actions
`define WM_NORMAL     2'h0
`define WM_FREQ       2'h1
`define WM_SINGLE     2'h2
`define WM_DUAL       2'h3
`define EA_NONE       3'h0
`define EA_CAPTURE    3'h1
`define EA_UPDOWN     3'h2
`define EA_RESTART    3'h3
`define EA_FREQCAP    3'h4
`define EA_PWCAP      3'h5

// reset values and timing
`define PERIOD_RST    16'hffff
`define CTRL_RST      16'h0000
`define NC_SAMPLES    4
`endif

// ### sim/timer_unit_checker.sv
// concurrent checks on the timer unit ports
`timescale 1ns/100ps
`include "timer_unit_defs.vh"
module timer_unit_checker (
  // clock and reset
  input wire        ref_clk,
  input wire        reset_n,
  // register port
  input wire [3:0]  reg_addr,
  input wire [15:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [15:0] reg_rdata,
  // events
  input wire [7:0]  ev_in,
  input wire        ovf_event,
  input wire        err_event,
  input wire [3:0]  comp_event,
  input wire        high_unf_event,
  // pins
  input wire [7:0]  port_value,
  input wire [7:0]  pin_out,
  input wire [7:0]  wave_out
);
  reg [7:0] fmask_reg;
  reg       ovr_seen_reg;
  reg       split_seen_reg;
  // ---------------------------------
  // shadow of the settings that matter
  // ---------------------------------
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      fmask_reg      <= 8'h00;
      ovr_seen_reg   <= 1'b0;
      split_seen_reg <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == `ADDR_FAULT) fmask_reg <= reg_wdata[7:0];
      if (reg_addr == `ADDR_PATTERN || reg_addr == `ADDR_CTRLC) ovr_seen_reg <= 1'b1;
      if (reg_addr == `ADDR_CTRLB && reg_wdata[`SPLIT_BIT]) split_seen_reg <= 1'b1;
    end
  end
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // fault event followed one cycle later by a port held low
  sequence s_fault_hit;
    (|(ev_in & fmask_reg)) ##1 (port_value == 8'h00);
  endsequence
  // ---------------------------------
  // assertions
  // ---------------------------------
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data outside its slot");
  a_unmapped_rd: assert property (reg_rd && reg_addr > 4'h8 && reg_addr < 4'hc |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_mask_rb: assert property (reg_rd && reg_addr == `ADDR_FAULT |=> reg_rdata[7:0] == fmask_reg)
    else $error("fault mask readback wrong");
  a_fault_off: assert property (s_fault_hit |=> pin_out == 8'h00)
    else $error("pins not off after fault");
  a_port_pass: assert property ($past(reset_n) && !ovr_seen_reg |-> pin_out == $past(port_value))
    else $error("pin differs from port value");
  a_ovf_pulse: assert property (ovf_event |=> !ovf_event)
    else $error("overflow event longer than a cycle");
  a_comp_pulse: assert property (comp_event[0] |=> !comp_event[0])
    else $error("channel event longer than a cycle");
  a_hunf_pulse: assert property (high_unf_event |=> !high_unf_event)
    else $error("high underflow longer than a cycle");
  a_hunf_split: assert property (high_unf_event |-> split_seen_reg)
    else $error("high underflow outside split");
  a_high_quiet: assert property (!split_seen_reg |-> wave_out[7:4] == 4'h0)
    else $error("high byte waves outside split");
endmodule
bind timer_unit timer_unit_checker chk_i (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ev_in(ev_in),
  .ovf_event(ovf_event), .err_event(err_event), .comp_event(comp_event), .high_unf_event(high_unf_event),
  .port_value(port_value), .pin_out(pin_out), .wave_out(wave_out));

// ### sim/event_system_model.sv
// behavioural event routing source feeding the timer unit
`timescale 1ns/100ps
module event_system_model (
  // clock and reset
  input  wire       ref_clk,
  input  wire       reset_n,
  // requests from the bench
  input  wire [7:0] ev_req,
  input  wire       slow,
  // event channels toward the timer
  output reg  [7:0] ev_in
);
  reg [7:0] hold_reg;
  // slow mode stretches an event to two cycles, as a level source would
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ev_in    <= 8'h00;
      hold_reg <= 8'h00;
    end else begin
      hold_reg <= slow ? ev_req : 8'h00;
      ev_in    <= ev_req | hold_reg;
    end
  end
endmodule

// ### sim/tb_timer_unit.sv
// self-checking bench for the timer unit
`timescale 1ns/100ps
`include "timer_unit_defs.vh"
module tb_timer_unit;
  reg         ref_clk, reset_n, reg_wr, reg_rd, rnd_on, slow;
  reg  [3:0]  reg_addr;
  reg  [15:0] reg_wdata, d, e;
  reg  [7:0]  port_value, ev_req;
  wire [15:0] reg_rdata;
  wire [7:0]  ev_in, pin_out, wave_out;
  wire [3:0]  comp_event;
  wire        ovf_event, err_event, high_unf_event;
  wire [3:0]  evs = {err_event, comp_event[0], high_unf_event, ovf_event};
  int         err_total, checks, cyc, n, i;

  timer_unit #(.FOUR_CH(1)) timer_unit_i (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ev_in(ev_in),
    .ovf_event(ovf_event), .err_event(err_event), .comp_event(comp_event),
    .high_unf_event(high_unf_event), .port_value(port_value), .pin_out(pin_out), .wave_out(wave_out));
  event_system_model event_system_model_i (.ref_clk(ref_clk), .reset_n(reset_n), .ev_req(ev_req),
    .slow(slow), .ev_in(ev_in));

  initial begin
    ref_clk = 1'b0;
    // fine resolution steps ride on phase ticks, so no faster clock is needed here
    forever #5 ref_clk = ~ref_clk;
  end
  // first wrap runs the full reset period, so the ceiling sits above it
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_total++;
      summarize();
    end
  end
  always @(posedge ref_clk) port_value <= rnd_on ? 8'($urandom) : 8'h00;

  function [15:0] wrap_len(input [15:0] p);
    return p + 16'h0001;
  endfunction
  task summarize;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string nm, input [15:0] seen, input [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input [3:0] a, input [15:0] v);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input [3:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task wait_on(input int s, input int lim);
    n = 0;
    do begin
      @(posedge ref_clk);
      #1 n++;
    end while (n < lim && evs[s] !== 1'b1);
  endtask
  task fire(input [7:0] m);
    @(posedge ref_clk);
    ev_req <= m;
    @(posedge ref_clk);
    ev_req <= 8'h00;
  endtask

  initial begin
    {reset_n, reg_wr, reg_rd, rnd_on, slow} = 5'h00;
    {reg_addr, reg_wdata, ev_req} = 28'h0;
    {err_total, checks, cyc} = 0;
    n = $urandom(32'h88222fc9);
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    rnd_on <= 1'b1;
    rd(`ADDR_PERIOD); chk("period reset", d, `PERIOD_RST);
    rd(`ADDR_CTRLB); chk("ctrlb reset", d, `CTRL_RST);
    wr(4'h9, 16'h5a5a); rd(4'h9); chk("unmapped", d, 16'h0000);
    for (i = 0; i < 8; i++) begin
      e = 16'($urandom);
      wr(`ADDR_FAULT, e); rd(`ADDR_FAULT); chk("fault mask", {8'h00, d[7:0]}, {8'h00, e[7:0]});
    end
    wr(`ADDR_FAULT, 16'h0000);
    // staged period only lands at the wrap of the old one
    wr(`ADDR_PERIOD, 16'h0003); wr(`ADDR_CLKSEL, 16'h0001);
    wait_on(0, 70000); chk("staged period", {15'h0, n == 65536}, 16'h0001);
    for (i = 0; i < 2; i++) begin
      wr(`ADDR_CTRLB, i ? 16'h0004 : 16'h0000);
      wait_on(0, 20); wait_on(0, 20); chk("wrap length", n[15:0], wrap_len(16'h0003));
    end
    wr(`ADDR_CTRLB, 16'h1210);
    fire(8'h02); wait_on(2, 12); chk("capture", {15'h0, n < 12}, 16'h0001);
    slow = 1'b1;
    fire(8'h02); wait_on(3, 12); chk("unread capture", {15'h0, n < 12}, 16'h0001);
    slow = 1'b0;
    // single slope on channels a and b over a period of 3
    wr(`ADDR_CTRLB, 16'h0032); wr(`ADDR_COMP0, 16'h0002); wr(`ADDR_COMP0 + 4'h1, 16'h0001);
    repeat (8) @(posedge ref_clk);
    {d, e} = 32'h0;
    repeat (16) begin
      @(posedge ref_clk);
      #1 e = e + wave_out[0];
      d = d + wave_out[1];
    end
    chk("pwm duty a", e, 16'h0008);
    chk("pwm duty b", d, 16'h0004);
    wr(`ADDR_CTRLB, 16'h0000); wr(`ADDR_PERIOD, 16'h0203);
    repeat (8) @(posedge ref_clk);
    wr(`ADDR_CTRLB, 16'h0008);
    wait_on(1, 20); wait_on(1, 20); chk("high underflow", n[15:0], wrap_len(16'h0002));
    wait_on(0, 20); wait_on(0, 20); chk("low underflow", n[15:0], wrap_len(16'h0003));
    wr(`ADDR_PATTERN, 16'hffff); wr(`ADDR_CTRLC, 16'h0008);
    repeat (8) @(posedge ref_clk);
    #1 chk("pattern pins", {8'h00, pin_out}, 16'h00ff);
    wr(`ADDR_FAULT, 16'h0001);
    rnd_on <= 1'b0;
    fire(8'h01);
    repeat (3) @(posedge ref_clk);
    #1 chk("fault pins", {8'h00, pin_out}, 16'h0000);
    rd(`ADDR_STATUS); chk("fault flag", {15'h0, d[0]}, 16'h0001);
    wr(`ADDR_STATUS, 16'h0001); rd(`ADDR_STATUS); chk("fault clear", {15'h0, d[0]}, 16'h0000);
    chk("pins back", {8'h00, pin_out}, 16'h00ff);
    summarize();
  end
endmodule
